// ### rtl/spi_ctrl_pkg.sv
// Register map, control fields and timing constants of the SPI control block
package spi_ctrl_pkg;
  localparam int ADDR_W = 8;
  localparam int BYTE_W = 8;
  localparam int FIFO_DEPTH = 4;
  localparam int CNT_W = 3;
  localparam int IRQ_W = 4;

  localparam logic [ADDR_W-1:0] STATUS_OFF = 8'h00;
  localparam logic [ADDR_W-1:0] RX_OFF = 8'h04;
  localparam logic [ADDR_W-1:0] TX_OFF = 8'h08;
  localparam logic [ADDR_W-1:0] DIV_OFF = 8'h0c;
  localparam logic [ADDR_W-1:0] CTRL_OFF = 8'h10;
  localparam logic [ADDR_W-1:0] IRQ_STAT_OFF = 8'h14;
  localparam logic [ADDR_W-1:0] IRQ_MASK_OFF = 8'h18;

  localparam logic [15:0] CTRL_RESET = 16'h0000;
  localparam logic [7:0] DIV_RESET = 8'h1b;
  localparam logic [IRQ_W-1:0] IRQ_RESET = 4'h0;

  // Control field positions
  localparam int CTRL_EN = 0;
  localparam int CTRL_MASTER = 1;
  localparam int CTRL_CPHA = 2;
  localparam int CTRL_CPOL = 3;
  localparam int CTRL_LSB = 5;
  localparam int CTRL_TRIG = 6;
  localparam int CTRL_ZERO = 7;
  localparam int CTRL_OEN = 9;
  localparam int CTRL_LOOP = 10;
  localparam int CTRL_CONT = 11;
  localparam int CTRL_RFLH = 12;
  localparam int CTRL_TFLH = 13;
  localparam int CTRL_THR = 14;

  // Interrupt status and mask bit positions
  localparam int IRQ_TX = 0;
  localparam int IRQ_RX = 1;
  localparam int IRQ_OVF = 2;
  localparam int IRQ_UF = 3;

  // Serial clock edges per byte and half periods of the stall between bytes
  localparam logic [4:0] LAST_TOGGLE = 5'd15;
  localparam logic [4:0] LAST_GAP_HALF = 5'd1;
  localparam logic [3:0] LAST_BIT = 4'd7;

  typedef enum logic [2:0]
  {
    ST_IDLE = 3'b000,
    ST_LEAD = 3'b001,
    ST_SHIFT = 3'b011,
    ST_TAIL = 3'b010,
    ST_GAP = 3'b110
  } mstate_t;

  function automatic logic [CNT_W-1:0] thr_bytes(input logic [1:0] code);
    return {1'b0, code} + 3'd1;
  endfunction
endpackage

// ### rtl/two_flop_sync.sv
// Two flip-flop synchroniser for pin inputs
`timescale 1ns/1ns
module two_flop_sync #(
  parameter int W = 1
) (
  input wire logic ref_clk_i,
  input wire logic srst_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  typedef struct packed
  {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } sync_t;

  sync_t st;
  sync_t next_st;

  if (W < 1)
  begin : g_bad_w
    $error("two_flop_sync needs W of at least 1");
  end

  always_comb
  begin
    next_st.s1 = d_i;
    next_st.s2 = st.s1;
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (srst_i)
      st <= '0;
    else
      st <= next_st;
  end

  assign q_o = st.s2;
endmodule

// ### rtl/byte_fifo.sv
// Small byte FIFO with a registered head word and a level count
`timescale 1ns/1ns
module byte_fifo #(
  parameter int W = 8,
  parameter int DEPTH = 4
) (
  input wire logic ref_clk_i,
  input wire logic srst_i,
  input wire logic flush_i,
  input wire logic push_i,
  input wire logic [W-1:0] data_i,
  input wire logic pop_i,
  output logic [W-1:0] data_o,
  output logic [$clog2(DEPTH+1)-1:0] count_o,
  output logic full_o,
  output logic empty_o
);
  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH+1);

  typedef struct packed
  {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [PW-1:0] wr;
    logic [PW-1:0] rd;
    logic [CW-1:0] cnt;
    logic [W-1:0] head;
  } fifo_state_t;

  fifo_state_t st;
  fifo_state_t next_st;
  logic do_push;
  logic do_pop;

  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || W < 1)
  begin : g_bad_depth
    $error("byte_fifo needs a power-of-two DEPTH of at least 2");
  end

  always_comb
  begin
    next_st = st;
    do_pop = pop_i && st.cnt != '0;
    // A push into a full FIFO is dropped; only the receive-side caller reports overflow
    do_push = push_i && st.cnt != CW'(DEPTH);
    if (flush_i)
    begin
      next_st.wr = '0;
      next_st.rd = '0;
      next_st.cnt = '0;
    end
    else
    begin
      if (do_push)
      begin
        next_st.mem[st.wr] = data_i;
        next_st.wr = st.wr + PW'(1);
      end
      if (do_pop)
        next_st.rd = st.rd + PW'(1);
      next_st.cnt = st.cnt + CW'(do_push) - CW'(do_pop);
    end
    next_st.head = next_st.mem[next_st.rd];
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (srst_i)
      st <= '0;
    else
      st <= next_st;
  end

  assign data_o = st.head;
  assign count_o = st.cnt;
  assign full_o = st.cnt == CW'(DEPTH);
  assign empty_o = st.cnt == '0;
endmodule

// ### rtl/spi_control_fifo_modes.sv
// SPI port with FIFO thresholds, flushes, continuous mode, loopback and APB registers
//
// What this block does
// - Threshold code 00..11 raises transmit interrupt after one to four bytes sent, with trigger mode set only.
// - With trigger mode clear, receive interrupt when FIFO holds at least code plus one bytes, four when 11.
// - Transmit flush bit held empties the transmit FIFO within one cycle.
// - Writes to the transmit FIFO are dropped while transmit flush is set.
// - With transmit flush held, filler is shifted: zero or the last byte.
// - Receive flush bit held empties the receive FIFO within one cycle.
// - Receive flush drops incoming bytes and suppresses every interrupt request.
// - Receive flush with read-trigger mode: a receive read still launches a transfer.
// - Continuous master mode keeps shifting bytes with chip select low until empty.
// - Single-byte mode sends one byte, then stalls one serial clock before next.
// - Loopback routes serial output straight back to serial input.
// - Slave output drives normally when enabled, otherwise behaves open drain.
// - Trigger mode clear: receive read starts; set: transmit write starts.
// - Zero fill with empty transmit FIFO shifts out a zero byte.
// - Master drives active-low chip select during each transfer automatically.
`timescale 1ns/1ns
module spi_control_fifo_modes (
  input wire logic ref_clk_i,
  input wire logic srst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [spi_ctrl_pkg::ADDR_W-1:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  output logic irq_o,
  input wire logic sclk_i,
  input wire logic chip_select_n_i,
  input wire logic mosi_i,
  input wire logic miso_i,
  output logic sclk_o,
  output logic mosi_o,
  output logic chip_select_n_o,
  output logic master_drive_n_o,
  output logic slave_data_out_pin_o,
  output logic slave_data_out_oe_n_o
);
  import spi_ctrl_pkg::*;

  typedef struct packed
  {
    logic [15:0] ctrl;
    logic [7:0] div;
    logic [IRQ_W-1:0] irq_stat;
    logic [IRQ_W-1:0] irq_mask;
    logic [31:0] rdata;
    mstate_t mst;
    logic [7:0] half_cnt;
    logic [4:0] toggles;
    logic sclk;
    logic [BYTE_W-1:0] tx_sh;
    logic [BYTE_W-1:0] rx_sh;
    logic [3:0] bits;
    logic [BYTE_W-1:0] last_tx;
    logic [CNT_W-1:0] tx_sent;
    logic rd_req;
    logic sclk_prev;
    logic cs_prev;
  } state_t;

  state_t st, next_st;
  logic s_sclk, s_cs_n, s_mosi, s_miso;
  logic [BYTE_W-1:0] tx_head, rx_head;
  logic [CNT_W-1:0] tx_count, rx_count;
  logic tx_full, tx_empty, rx_full, rx_empty;

  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] off);
    return a == off;
  endfunction
  function automatic logic mapped(input logic [ADDR_W-1:0] a);
    return hit(a, STATUS_OFF) || hit(a, RX_OFF) || hit(a, TX_OFF) || hit(a, DIV_OFF) ||
      hit(a, CTRL_OFF) || hit(a, IRQ_STAT_OFF) || hit(a, IRQ_MASK_OFF);
  endfunction

  // Bus decode
  logic setup_cyc, access_cyc, wr_acc, rd_acc, wr_tx, rd_rx;
  assign setup_cyc = psel_i && !penable_i;
  assign access_cyc = psel_i && penable_i;
  assign wr_acc = access_cyc && pwrite_i && mapped(paddr_i);
  assign rd_acc = access_cyc && !pwrite_i && mapped(paddr_i);
  assign wr_tx = wr_acc && hit(paddr_i, TX_OFF);
  assign rd_rx = rd_acc && hit(paddr_i, RX_OFF);
  // Control fields
  logic en, is_master, cpha, cpol, lsb_first, trig, zero_fill_en, slave_out_drive_en;
  logic loopback_en, continuous_transfer_en, rx_fifo_flush, tx_fifo_flush;
  logic [CNT_W-1:0] thr;
  assign en = st.ctrl[CTRL_EN];
  assign is_master = en && st.ctrl[CTRL_MASTER];
  assign cpha = st.ctrl[CTRL_CPHA];
  assign cpol = st.ctrl[CTRL_CPOL];
  assign lsb_first = st.ctrl[CTRL_LSB];
  assign trig = st.ctrl[CTRL_TRIG];
  assign zero_fill_en = st.ctrl[CTRL_ZERO];
  assign slave_out_drive_en = st.ctrl[CTRL_OEN];
  assign loopback_en = st.ctrl[CTRL_LOOP];
  assign continuous_transfer_en = st.ctrl[CTRL_CONT];
  assign rx_fifo_flush = st.ctrl[CTRL_RFLH];
  assign tx_fifo_flush = st.ctrl[CTRL_TFLH];
  assign thr = thr_bytes(st.ctrl[CTRL_THR+1:CTRL_THR]);
  // Serial engine: one shift path for master and slave, edges from either source
  logic slave_active, cs_fall, m_toggle, m_start, m_last, m_cont, edge_any, lvl, leading;
  logic sample, change, out_bit, in_bit, byte_done, load, tx_pop, rx_push;
  logic [BYTE_W-1:0] rx_byte, fill_byte, load_byte;
  logic [IRQ_W-1:0] ev;
  assign slave_active = en && !st.ctrl[CTRL_MASTER] && !s_cs_n;
  assign cs_fall = slave_active && st.cs_prev;
  assign m_toggle = st.mst == ST_SHIFT && st.half_cnt == st.div;
  assign m_last = m_toggle && st.toggles == LAST_TOGGLE;
  assign m_start = st.mst == ST_IDLE && is_master && (trig ? !tx_empty : st.rd_req);
  assign m_cont = m_last && continuous_transfer_en && !tx_empty;
  assign edge_any = is_master ? m_toggle : (slave_active && s_sclk != st.sclk_prev);
  assign lvl = is_master ? !st.sclk : s_sclk;
  assign leading = edge_any && (lvl != cpol);
  assign sample = edge_any && (leading != cpha);
  assign change = edge_any && !sample;
  assign out_bit = lsb_first ? st.tx_sh[0] : st.tx_sh[BYTE_W-1];
  assign in_bit = loopback_en ? out_bit : (is_master ? s_miso : s_mosi);
  assign byte_done = sample && st.bits == LAST_BIT;
  assign rx_byte = lsb_first ? {in_bit, st.rx_sh[BYTE_W-1:1]} : {st.rx_sh[BYTE_W-2:0], in_bit};
  assign load = m_start || m_cont || cs_fall || (slave_active && byte_done);
  assign fill_byte = zero_fill_en ? '0 : st.last_tx;
  assign load_byte = tx_empty ? fill_byte : tx_head;
  assign tx_pop = load && !tx_empty;
  // Incoming bytes are dropped while the receive flush is held
  assign rx_push = byte_done && !rx_fifo_flush;
  // Events; none is raised while the receive flush is held
  always_comb
  begin
    ev = '0;
    ev[IRQ_TX] = byte_done && trig && st.tx_sent == thr - 3'd1;
    ev[IRQ_RX] = rx_push && !trig && !rx_full && (rx_count + 3'd1 >= thr);
    ev[IRQ_OVF] = rx_push && rx_full;
    ev[IRQ_UF] = load && tx_empty && !tx_fifo_flush;
    if (rx_fifo_flush)
      ev = '0;
  end
  function automatic logic [31:0] read_mux(input state_t s, input logic [ADDR_W-1:0] a,
      input logic [CNT_W-1:0] rxc, input logic [CNT_W-1:0] txc, input logic [BYTE_W-1:0] rxh,
      input logic [CNT_W-1:0] t);
    logic [31:0] r;
    r = '0;
    if (hit(a, STATUS_OFF))
      r[11:0] = {rxc > t, rxc, s.irq_stat[IRQ_OVF], s.irq_stat[IRQ_RX], s.irq_stat[IRQ_TX],
        s.irq_stat[IRQ_UF], txc, |s.irq_stat};
    else if (hit(a, RX_OFF))
      r[BYTE_W-1:0] = rxh;
    else if (hit(a, DIV_OFF))
      r[7:0] = s.div;
    else if (hit(a, CTRL_OFF))
      r[15:0] = s.ctrl;
    else if (hit(a, IRQ_STAT_OFF))
      r[IRQ_W-1:0] = s.irq_stat;
    else if (hit(a, IRQ_MASK_OFF))
      r[IRQ_W-1:0] = s.irq_mask;
    return r;
  endfunction
  always_comb
  begin
    next_st = st;
    // Read data is taken in the setup cycle so that it leaves a flip-flop
    if (setup_cyc)
      next_st.rdata = read_mux(st, paddr_i, rx_count, tx_count, rx_head, thr);
    if (wr_acc && hit(paddr_i, CTRL_OFF))
      next_st.ctrl = pwdata_i[15:0];
    if (wr_acc && hit(paddr_i, DIV_OFF))
      next_st.div = pwdata_i[7:0];
    if (wr_acc && hit(paddr_i, IRQ_MASK_OFF))
      next_st.irq_mask = pwdata_i[IRQ_W-1:0];
    // A new event wins over a write-one clear in the same cycle
    if (wr_acc && hit(paddr_i, IRQ_STAT_OFF))
      next_st.irq_stat = st.irq_stat & ~pwdata_i[IRQ_W-1:0];
    next_st.irq_stat = next_st.irq_stat | ev;

    if (m_start)
      next_st.rd_req = 1'b0;
    // A receive read still launches a transfer under receive flush
    if (rd_rx && !trig && is_master)
      next_st.rd_req = 1'b1;

    next_st.sclk_prev = s_sclk;
    next_st.cs_prev = s_cs_n;
    if (sample)
    begin
      next_st.rx_sh = rx_byte;
      next_st.bits = byte_done ? '0 : st.bits + 4'd1;
    end
    // No shift before the first sample, so the loaded first bit stays on the line
    if (change && st.bits != '0)
      next_st.tx_sh = lsb_first ? {1'b0, st.tx_sh[BYTE_W-1:1]} : {st.tx_sh[BYTE_W-2:0], 1'b0};
    if (load)
    begin
      next_st.tx_sh = load_byte;
      next_st.last_tx = load_byte;
    end
    if (!is_master && !slave_active)
      next_st.bits = '0;
    if (byte_done && trig)
      next_st.tx_sent = (st.tx_sent == thr - 3'd1) ? '0 : st.tx_sent + 3'd1;
    if (!trig)
      next_st.tx_sent = '0;

    case (st.mst)
      ST_IDLE:
      begin
        next_st.sclk = cpol;
        next_st.half_cnt = '0;
        if (m_start)
        begin
          next_st.mst = ST_LEAD;
          next_st.bits = '0;
        end
      end
      ST_LEAD:
      begin
        next_st.half_cnt = st.half_cnt + 8'd1;
        if (st.half_cnt == st.div)
        begin
          next_st.mst = ST_SHIFT;
          next_st.half_cnt = '0;
          next_st.toggles = '0;
        end
      end
      ST_SHIFT:
      begin
        next_st.half_cnt = st.half_cnt + 8'd1;
        if (m_toggle)
        begin
          next_st.sclk = !st.sclk;
          next_st.half_cnt = '0;
          next_st.toggles = st.toggles + 5'd1;
          if (m_last)
          begin
            next_st.toggles = '0;
            // Chip select stays low straight into the next byte
            if (!m_cont)
              next_st.mst = ST_TAIL;
          end
        end
      end
      ST_TAIL:
      begin
        next_st.half_cnt = st.half_cnt + 8'd1;
        if (st.half_cnt == st.div)
        begin
          next_st.mst = ST_GAP;
          next_st.half_cnt = '0;
          next_st.toggles = '0;
        end
      end
      ST_GAP:
      begin
        // One full serial clock of stall before the next single byte
        next_st.half_cnt = st.half_cnt + 8'd1;
        if (st.half_cnt == st.div)
        begin
          next_st.half_cnt = '0;
          next_st.toggles = st.toggles + 5'd1;
          if (st.toggles == LAST_GAP_HALF)
            next_st.mst = ST_IDLE;
        end
      end
      default:
      begin
        next_st.mst = ST_IDLE;
      end
    endcase
    if (!is_master)
    begin
      next_st.mst = ST_IDLE;
      next_st.sclk = cpol;
    end
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (srst_i)
      st <= '{ctrl: CTRL_RESET, div: DIV_RESET, irq_stat: IRQ_RESET, irq_mask: IRQ_RESET,
        mst: ST_IDLE, cs_prev: 1'b1, default: '0};
    else
      st <= next_st;
  end

  two_flop_sync #(.W(4)) u_pin_sync (
    .ref_clk_i(ref_clk_i),
    .srst_i(srst_i),
    .d_i({sclk_i, chip_select_n_i, mosi_i, miso_i}),
    .q_o({s_sclk, s_cs_n, s_mosi, s_miso})
  );

  byte_fifo #(.W(BYTE_W), .DEPTH(FIFO_DEPTH)) u_tx_fifo (
    .ref_clk_i(ref_clk_i),
    .srst_i(srst_i),
    .flush_i(tx_fifo_flush),
    .push_i(wr_tx && !tx_fifo_flush),
    .data_i(pwdata_i[BYTE_W-1:0]),
    .pop_i(tx_pop),
    .data_o(tx_head),
    .count_o(tx_count),
    .full_o(tx_full),
    .empty_o(tx_empty)
  );

  byte_fifo #(.W(BYTE_W), .DEPTH(FIFO_DEPTH)) u_rx_fifo (
    .ref_clk_i(ref_clk_i),
    .srst_i(srst_i),
    .flush_i(rx_fifo_flush),
    .push_i(rx_push),
    .data_i(rx_byte),
    .pop_i(rd_rx && !rx_empty),
    .data_o(rx_head),
    .count_o(rx_count),
    .full_o(rx_full),
    .empty_o(rx_empty)
  );

  assign prdata_o = st.rdata;
  assign pready_o = 1'b1;
  assign pslverr_o = access_cyc && !mapped(paddr_i);
  assign irq_o = |(st.irq_stat & st.irq_mask) && !rx_fifo_flush;
  assign sclk_o = st.sclk;
  assign mosi_o = out_bit;
  assign chip_select_n_o = !(st.mst == ST_LEAD || st.mst == ST_SHIFT || st.mst == ST_TAIL);
  assign master_drive_n_o = !is_master;
  // Open drain: with the drive bit clear only a low level is ever driven
  assign slave_data_out_pin_o = slave_out_drive_en ? out_bit : 1'b0;
  assign slave_data_out_oe_n_o = !(slave_active && (slave_out_drive_en || !out_bit));

  a_tx_flush_empty: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    tx_fifo_flush |=> tx_count == '0) else $error("tx FIFO not empty under flush");
  a_tx_write_drop: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    (wr_tx && tx_fifo_flush) |=> tx_empty) else $error("tx write taken under flush");
  a_rx_flush_empty: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    rx_fifo_flush |=> rx_count == '0) else $error("rx FIFO not empty under flush");
  a_rx_flush_quiet: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    rx_fifo_flush |-> !irq_o && ev == '0) else $error("interrupt raised under rx flush");
  a_read_launch: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    (st.mst == ST_IDLE && st.rd_req && is_master && !trig && $stable(st.ctrl))
      |=> st.mst == ST_LEAD && !chip_select_n_o) else $error("rx read did not launch");
  a_cont_cs_held: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    (m_cont && $stable(st.ctrl)) |=> st.mst == ST_SHIFT && !chip_select_n_o)
    else $error("continuous byte released chip select");
  a_gap_stall: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    (st.mst == ST_TAIL && next_st.mst == ST_GAP) |=> (st.mst == ST_GAP)[*2])
    else $error("stall between bytes too short");
  a_loop_route: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    (loopback_en && sample && !lsb_first) |=> st.rx_sh[0] == $past(mosi_o))
    else $error("loopback not routed");
  a_open_drain: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    (!slave_out_drive_en && !slave_data_out_oe_n_o) |-> !slave_data_out_pin_o)
    else $error("open-drain pin driven high");
  a_zero_fill: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    (load && tx_empty && zero_fill_en) |=> st.tx_sh == '0) else $error("zero fill not sent");
  a_rx_threshold: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    (rx_push && !trig && rx_count == thr - 3'd1) |=> st.irq_stat[IRQ_RX])
    else $error("rx threshold missed");
  a_cs_shift_low: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    $rose(st.mst == ST_SHIFT) |-> !chip_select_n_o && $past(!chip_select_n_o))
    else $error("chip select high while shifting");
endmodule

// ### test/spi_peer_model.sv
// SPI slave peer on the far side of the master port
`timescale 1ns/1ns
module spi_peer_model (
  input wire logic sclk_i,
  input wire logic cs_n_i,
  input wire logic mosi_i,
  input wire logic [7:0] reply_i,
  output logic miso_o,
  output logic [7:0] got_o,
  output int frames_o,
  output int bytes_o
);
  logic [7:0] tx;
  logic [7:0] rx;
  int nb;
  initial
  begin
    miso_o = 1'b0;
    got_o = 8'h00;
    frames_o = 0;
    bytes_o = 0;
    nb = 0;
  end
  always @(negedge cs_n_i)
  begin
    frames_o++;
    nb = 0;
    tx = reply_i;
    miso_o = tx[7];
  end
  // Released line has no pull: show the inverse so a stale bit never passes as data
  always @(posedge cs_n_i) miso_o = ~miso_o;
  always @(posedge sclk_i)
    if (!cs_n_i)
    begin
      rx = {rx[6:0], mosi_i};
      nb++;
      if (nb == 8)
      begin
        got_o = rx;
        bytes_o++;
        nb = 0;
      end
    end
  // Mode 0: next bit goes out on the trailing edge
  always @(negedge sclk_i)
    if (!cs_n_i)
    begin
      tx = (nb == 0) ? reply_i : {tx[6:0], 1'b0};
      miso_o = tx[7];
    end
endmodule

// ### test/spi_control_fifo_modes_tb.sv
// Self-checking bench for the SPI control block, master transfers and slave pin drive
`timescale 1ns/1ns
module spi_control_fifo_modes_tb;
  import spi_ctrl_pkg::*;
  logic clk = 1'b0, srst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, perr, irq, sclk, mosi, csn, miso;
  logic mdrv_n, sdo, sdo_oe_n, scs_n = 1'b1;
  logic [7:0] reply = 8'h3c, got;
  int frames, nbytes, f0, err_count = 0, checks = 0, cyc = 0;
  always #5 clk = ~clk;

  spi_control_fifo_modes DUT (.ref_clk_i(clk), .srst_i(srst), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .irq_o(irq),
    .sclk_i(1'b0), .chip_select_n_i(scs_n), .mosi_i(1'b0), .miso_i(miso),
    .sclk_o(sclk), .mosi_o(mosi), .chip_select_n_o(csn), .master_drive_n_o(mdrv_n),
    .slave_data_out_pin_o(sdo), .slave_data_out_oe_n_o(sdo_oe_n));
  spi_peer_model peer (.sclk_i(sclk), .cs_n_i(csn), .mosi_i(mosi), .reply_i(reply),
    .miso_o(miso), .got_o(got), .frames_o(frames), .bytes_o(nbytes));

  task automatic finish_test();
    $display("checks %0d err_count %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] act);
    checks++;
    if (act !== exp)
    begin
      err_count++;
      $display("BAD %s expected %h seen %h", name, exp, act);
    end
  endtask

  // Entered right after a rising edge; leaves one idle cycle behind it
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    // Only the bench timeout ends a wait for the slave
    while (pready !== 1'b1)
      @(posedge clk);
    rd = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  // Waits for the peer to count n bytes, then lets the tail and gap run out
  task automatic wait_bytes(input int n, input int post);
    while (nbytes < n)
      @(posedge clk);
    repeat (post) @(posedge clk);
  endtask

  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      err_count++;
      finish_test();
    end
  end

  initial
  begin
    repeat (6) @(posedge clk);
    srst <= 1'b0;
    apb(1'b0, CTRL_OFF, 32'h0);
    chk("ctrl", 32'h0, rd);
    apb(1'b0, DIV_OFF, 32'h0);
    chk("div", 32'h1b, rd);
    apb(1'b0, 8'h1c, 32'h0);
    chk("unmapped", 32'h1, 32'(perr));
    wr(DIV_OFF, 32'h3);
    wr(IRQ_MASK_OFF, 32'h1);
    wr(CTRL_OFF, 32'h4043);
    f0 = frames;
    wr(TX_OFF, 32'ha5);
    wait_bytes(1, 24);
    chk("mosi byte", 32'ha5, 32'(got));
    chk("irq one", 32'h0, 32'(irq));
    wr(TX_OFF, 32'h96);
    wait_bytes(2, 24);
    chk("irq two", 32'h1, 32'(irq));
    chk("frames", 32'h2, 32'(frames - f0));
    wr(IRQ_STAT_OFF, 32'h1);
    chk("irq clear", 32'h0, 32'(irq));
    apb(1'b0, RX_OFF, 32'h0);
    chk("rx", 32'h3c, rd);
    wr(CTRL_OFF, 32'h4843);
    f0 = frames;
    wr(TX_OFF, 32'h11);
    wr(TX_OFF, 32'h22);
    wr(TX_OFF, 32'h77);
    wait_bytes(5, 24);
    chk("cont frames", 32'h1, 32'(frames - f0));
    chk("cont last", 32'h77, 32'(got));
    wr(CTRL_OFF, 32'h0003);
    wr(TX_OFF, 32'h44);
    wr(TX_OFF, 32'h55);
    apb(1'b0, STATUS_OFF, 32'h0);
    chk("tx level", 32'h2, 32'(rd[3:1]));
    wr(CTRL_OFF, 32'h2003);
    apb(1'b0, STATUS_OFF, 32'h0);
    chk("tx flushed", 32'h0, 32'(rd[3:1]));
    wr(TX_OFF, 32'h66);
    wr(CTRL_OFF, 32'h0003);
    apb(1'b0, STATUS_OFF, 32'h0);
    chk("tx dropped", 32'h0, 32'(rd[3:1]));
    wr(IRQ_MASK_OFF, 32'hf);
    wr(CTRL_OFF, 32'h3003);
    apb(1'b0, RX_OFF, 32'h0);
    wait_bytes(6, 24);
    chk("filler last", 32'h77, 32'(got));
    apb(1'b0, STATUS_OFF, 32'h0);
    chk("rx flushed", 32'h0, 32'(rd[10:8]));
    chk("irq muted", 32'h0, 32'(irq));
    wr(CTRL_OFF, 32'h3083);
    apb(1'b0, RX_OFF, 32'h0);
    wait_bytes(7, 24);
    chk("zero fill", 32'h0, 32'(got));
    wr(IRQ_STAT_OFF, 32'hf);
    wr(IRQ_MASK_OFF, 32'h2);
    wr(CTRL_OFF, 32'h4803);
    wr(TX_OFF, 32'h81);
    wr(TX_OFF, 32'h82);
    apb(1'b0, RX_OFF, 32'h0);
    wait_bytes(8, 8);
    chk("rx irq one", 32'h0, 32'(irq));
    wait_bytes(9, 24);
    chk("rx irq two", 32'h1, 32'(irq));
    wr(CTRL_OFF, 32'h1000);
    wr(CTRL_OFF, 32'h0443);
    reply <= 8'hc3;
    wr(TX_OFF, 32'h5a);
    wait_bytes(10, 24);
    apb(1'b0, RX_OFF, 32'h0);
    chk("loop rx", 32'h5a, rd);
    chk("master drive", 32'h0, 32'(mdrv_n));
    wr(CTRL_OFF, 32'h0001);
    wr(TX_OFF, 32'h80);
    scs_n <= 1'b0;
    repeat (6) @(posedge clk);
    chk("od level", 32'h0, 32'(sdo));
    chk("od release", 32'h1, 32'(sdo_oe_n));
    wr(CTRL_OFF, 32'h0201);
    chk("drive level", 32'h1, 32'(sdo));
    chk("drive enable", 32'h0, 32'(sdo_oe_n));
    chk("slave drive", 32'h1, 32'(mdrv_n));
    scs_n <= 1'b1;
    repeat (4) @(posedge clk);
    chk("deselect", 32'h1, 32'(sdo_oe_n));
    finish_test();
  end
endmodule
